// >>> shared/sprap_defs.svh
// serial register access port: offsets, field positions, timing counts
// assumes: included by bare name from package, design files and tb_top
`ifndef SPRAP_DEFS_SVH
`define SPRAP_DEFS_SVH
`define SPRAP_WORD_BITS 32
`define SPRAP_ADDR_BITS 6
`define SPRAP_DATA_BITS 24
`define SPRAP_NREGS 64
`define SPRAP_HDR_BITS 8
`define SPRAP_WR_POS 31
`define SPRAP_ADDR_MSB 30
`define SPRAP_ADDR_LSB 25
// upper bits of the two-wire slave address: arbitrary value, set per board
`define SPRAP_I2C_ADDR_HI 6'h08
`define SPRAP_RST_VAL 24'h000000
`define SPRAP_CLK_NS 25
`define SPRAP_SEL_HOLD_NS 15
`define SPRAP_SEL_HOLD_CYC ((`SPRAP_SEL_HOLD_NS + `SPRAP_CLK_NS - 1) / `SPRAP_CLK_NS)
// host serial clock half period in clk cycles: the device's two flops and
// edge detect plus the host's two flops take five cycles before data is seen
`define SPRAP_SCLK_HALF 8
`endif

// >>> shared/sprap_pkg.sv
// serial register access port: shared types
// assumes: sprap_defs.svh on the include path
`include "sprap_defs.svh"
package sprap_pkg;
    typedef enum logic [1:0] {
        SPRAP_MODE_SPI = 2'h1,
        SPRAP_MODE_I2C = 2'h2
    } sprap_mode_t;
    typedef logic [`SPRAP_DATA_BITS-1:0] sprap_data_t;
    typedef logic [`SPRAP_ADDR_BITS-1:0] sprap_addr_t;
endpackage

// >>> shared/sprap_if.sv
// serial register access port: the four shared pins
// assumes: the bench resolves the wires from the enables below
`timescale 1ns/100ps
interface sprap_if;
    logic sel;
    logic sclk;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    logic miso_i;
    modport dev (
        input sel,
        input sclk,
        input mosi,
        input miso_i,
        output miso_o,
        output miso_oe_n
    );
    modport host (
        output sel,
        output sclk,
        output mosi,
        input miso_i
    );
endinterface

// >>> core/sprap_device.sv
// serial register access port, device end: strap, 32-bit frame, map
// assumes: one clk at 40 MHz; link pins asynchronous to it
`timescale 1ns/100ps
`include "sprap_defs.svh"
module sprap_device #(
    parameter logic [`SPRAP_NREGS-1:0] POP_MASK = 64'hFFFF_FFFF_FFFF_FFFF,
    parameter logic [`SPRAP_DATA_BITS-1:0] RO_MASK = 24'h000000,
    parameter logic [`SPRAP_DATA_BITS-1:0] W1C_MASK = 24'h000000,
    parameter logic [`SPRAP_DATA_BITS-1:0] COR_MASK = 24'h000000,
    parameter logic [`SPRAP_DATA_BITS-1:0] USED_MASK = 24'hFFFFFF
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link
    sprap_if.dev link,
    // core side: hardware status and event inputs
    input wire logic [`SPRAP_DATA_BITS-1:0] hw_status,
    input wire logic [`SPRAP_DATA_BITS-1:0] hw_event,
    input wire logic [`SPRAP_ADDR_BITS-1:0] hw_addr,
    // core side: status
    output logic port_active,
    output sprap_pkg::sprap_mode_t mode,
    output logic [6:0] i2c_slave_addr,
    output logic write_pulse,
    output logic [`SPRAP_ADDR_BITS-1:0] write_addr
);
    logic [1:0] sel_sync_reg, clk_sync_reg, mosi_sync_reg;
    logic sclk_d_reg;
    logic strapped_reg;
    logic [`SPRAP_DATA_BITS-1:0] map_reg [`SPRAP_NREGS];
    logic [5:0] cnt_reg;
    logic [`SPRAP_WORD_BITS-1:0] shin_reg;
    logic [`SPRAP_DATA_BITS-1:0] shout_reg;
    logic [`SPRAP_ADDR_BITS-1:0] addr_reg;
    logic wr_reg, miso_reg;
    logic sel_s, sclk_s, mosi_s, rise, fall, spi_on;
    logic frame_clr, rd_load, commit;
    logic [`SPRAP_DATA_BITS-1:0] rd_view;

    // absent words read as zero; unused bits are masked on the way out
    function automatic logic [`SPRAP_DATA_BITS-1:0] read_view(
        input logic [`SPRAP_ADDR_BITS-1:0] a);
        if (POP_MASK[a])
            read_view = map_reg[a] & USED_MASK;
        else
            read_view = '0;
    endfunction

    assign sel_s = sel_sync_reg[1];
    assign sclk_s = clk_sync_reg[1];
    assign mosi_s = mosi_sync_reg[1];
    assign rise = sclk_s & ~sclk_d_reg;
    assign fall = ~sclk_s & sclk_d_reg;
    assign spi_on = port_active && mode == sprap_pkg::SPRAP_MODE_SPI;
    // the two-wire byte engine is not built: in that mode the frame logic
    // is held clear, so no transfer completes and only the hardware inputs change a register
    assign frame_clr = sys_rst || !spi_on || !sel_s;
    assign rd_view = read_view(addr_reg);
    assign rd_load = !frame_clr && fall && cnt_reg == 6'h08;
    assign commit = !frame_clr && fall && cnt_reg == 6'h20 && wr_reg;

    // two flops on every pin; the edge detect adds one more cycle of lag,
    // so the serial clock half period must stay well above three cycles
    always_ff @(posedge clk) begin
        sel_sync_reg <= {sel_sync_reg[0], link.sel};
        clk_sync_reg <= {clk_sync_reg[0], link.sclk};
        mosi_sync_reg <= {mosi_sync_reg[0], link.mosi};
        sclk_d_reg <= sclk_s;
    end

    // strap: the pin levels are taken once, on the first edge after reset,
    // while the port is still held inactive
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strapped_reg <= 1'b0;
            mode <= sprap_pkg::SPRAP_MODE_SPI;
            i2c_slave_addr <= 7'h00;
        end else if (!strapped_reg) begin
            strapped_reg <= 1'b1;
            mode <= sel_s ? sprap_pkg::SPRAP_MODE_I2C
                          : sprap_pkg::SPRAP_MODE_SPI;
            i2c_slave_addr <= {`SPRAP_I2C_ADDR_HI, mosi_s};
        end
    end

    // the port opens one edge after the strap, never in the same cycle,
    // so no frame can start on a half-decided mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_active <= 1'b0;
        end else if (strapped_reg) begin
            port_active <= 1'b1;
        end
    end

    // bit counter: cleared whenever select is low, so every frame starts
    // empty; parks at 33 once the commit edge has passed
    always_ff @(posedge clk) begin
        if (frame_clr) begin
            cnt_reg <= 6'h00;
        end else if (rise && cnt_reg < 6'h20) begin
            cnt_reg <= cnt_reg + 6'h01;
        end else if (fall && cnt_reg == 6'h20) begin
            cnt_reg <= 6'h21;
        end
    end

    // header capture on sampled rising edges; the address is complete when
    // the null bit arrives, which leaves half a period for the lookup
    always_ff @(posedge clk) begin
        if (frame_clr) begin
            shin_reg <= '0;
            wr_reg <= 1'b0;
            addr_reg <= '0;
        end else if (rise && cnt_reg < 6'h20) begin
            shin_reg <= {shin_reg[30:0], mosi_s};
            if (cnt_reg == 6'h00)
                wr_reg <= mosi_s;
            if (cnt_reg == 6'h07)
                addr_reg <= shin_reg[5:0];
        end
    end

    // data out: first bit on the falling edge after the null bit;
    // a write shifts out the old contents exactly like a read
    always_ff @(posedge clk) begin
        if (frame_clr) begin
            shout_reg <= '0;
            miso_reg <= 1'b0;
        end else if (rd_load) begin
            shout_reg <= rd_view << 1;
            miso_reg <= rd_view[`SPRAP_DATA_BITS-1];
        end else if (fall && cnt_reg > 6'h08 && cnt_reg < 6'h20) begin
            miso_reg <= shout_reg[`SPRAP_DATA_BITS-1];
            shout_reg <= shout_reg << 1;
        end
    end

    // commit strobe: one clock wide and registered, so a select drop that
    // comes after the 32nd fall cannot cut it short
    always_ff @(posedge clk) begin
        if (frame_clr) begin
            write_pulse <= 1'b0;
            write_addr <= '0;
        end else begin
            write_pulse <= commit;
            if (commit)
                write_addr <= addr_reg;
        end
    end

    // released whenever select is low; in two-wire mode it stays released
    assign link.miso_o = miso_reg;
    assign link.miso_oe_n = !(spi_on && sel_s);

    // register map: one process walks every word; hardware events are
    // applied last, so a set wins over a host clear in the same cycle
    always_ff @(posedge clk) begin
        logic [`SPRAP_DATA_BITS-1:0] wd, cur, nv;
        wd = shin_reg[`SPRAP_DATA_BITS-1:0] & USED_MASK;
        cur = '0;
        nv = '0;
        for (int i = 0; i < `SPRAP_NREGS; i++) begin
            cur = map_reg[i];
            nv = cur;
            if (sys_rst)
                nv = `SPRAP_RST_VAL;
            else begin
                if (write_pulse && write_addr == i[5:0] && POP_MASK[i]) begin
                    nv = (cur & RO_MASK) | (wd & ~RO_MASK & ~W1C_MASK
                         & ~COR_MASK) | (cur & W1C_MASK & ~wd);
                    nv = nv | (cur & COR_MASK);
                end
                if (rd_load && !wr_reg && addr_reg == i[5:0])
                    nv = nv & ~COR_MASK;
                if (hw_addr == i[5:0])
                    nv = (nv & ~RO_MASK) | (hw_status & RO_MASK)
                         | (hw_event & (W1C_MASK | COR_MASK));
            end
            // masked again on the way in so unused bits never hold a one
            map_reg[i] <= nv & USED_MASK;
        end
    end
endmodule // sprap_device

// >>> core/sprap_host.sv
// serial register access port, host end: drives one 32-bit frame
// assumes: one clk at 40 MHz; miso pin asynchronous
`timescale 1ns/100ps
`include "sprap_defs.svh"
module sprap_host (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link
    sprap_if.host link,
    // user request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [`SPRAP_ADDR_BITS-1:0] req_addr,
    input wire logic [`SPRAP_DATA_BITS-1:0] req_data,
    // user answer
    output logic rsp_valid,
    output logic [`SPRAP_DATA_BITS-1:0] rsp_data
);
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_SHIFT = 4'h2,
        H_HOLD = 4'h4,
        H_GAP = 4'h8
    } sprap_hstate_t;
    sprap_hstate_t st_reg;
    logic [1:0] miso_sync_reg;
    logic [2:0] div_reg;
    logic [5:0] bit_reg;
    logic [`SPRAP_WORD_BITS-1:0] sh_reg;
    logic [`SPRAP_DATA_BITS-1:0] rx_reg;
    logic tick, sclk_reg, sel_reg;
    logic [1:0] wait_reg;

    assign tick = div_reg == 3'(`SPRAP_SCLK_HALF - 1);
    assign req_ready = st_reg == H_IDLE;
    assign link.sclk = sclk_reg;
    assign link.sel = sel_reg;
    assign link.mosi = sh_reg[31];

    always_ff @(posedge clk)
        miso_sync_reg <= {miso_sync_reg[0], link.miso_i};

    always_ff @(posedge clk) begin
        if (sys_rst || st_reg != H_SHIFT || tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + 3'd1;
    end

    always_ff @(posedge clk) begin
        rsp_valid <= 1'b0;
        if (sys_rst) begin
            st_reg <= H_IDLE;
            sclk_reg <= 1'b0;
            sel_reg <= 1'b0;
            sh_reg <= '0;
            rx_reg <= '0;
            bit_reg <= '0;
            wait_reg <= '0;
            rsp_data <= '0;
        end else begin
            unique case (st_reg)
                H_IDLE: if (req_valid) begin
                    sel_reg <= 1'b1;
                    // on a read the data bits are don't-care, sent as given
                    sh_reg <= {req_write, req_addr, 1'b0, req_data};
                    bit_reg <= '0;
                    st_reg <= H_SHIFT;
                end
                H_SHIFT: if (tick) begin
                    sclk_reg <= ~sclk_reg;
                    if (!sclk_reg) begin
                        if (bit_reg >= 6'd8)
                            rx_reg <= {rx_reg[22:0], miso_sync_reg[1]};
                    end else begin
                        sh_reg <= sh_reg << 1;
                        bit_reg <= bit_reg + 6'd1;
                        if (bit_reg == 6'd31) begin
                            st_reg <= H_HOLD;
                            wait_reg <= '0;
                        end
                    end
                end
                H_HOLD: begin
                    // device needs sync and commit time after last edge
                    wait_reg <= wait_reg + 2'd1;
                    if (wait_reg == 2'(`SPRAP_SEL_HOLD_CYC + 2)) begin
                        sel_reg <= 1'b0;
                        rsp_valid <= 1'b1;
                        rsp_data <= rx_reg;
                        wait_reg <= '0;
                        st_reg <= H_GAP;
                    end
                end
                H_GAP: begin
                    wait_reg <= wait_reg + 2'd1;
                    if (wait_reg == 2'd3)
                        st_reg <= H_IDLE;
                end
            endcase
        end
    end
endmodule // sprap_host

// >>> tb/sprap_link_asserts.sv
// serial register access port: checker on the four link pins
// assumes: instantiated in tb_top beside the sprap_if instance
`timescale 1ns/100ps
module sprap_link_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link pins
    input wire logic sel,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n,
    input wire logic miso_i
);
    logic sclk_reg;
    logic [5:0] fall_cnt_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk) begin
        sclk_reg <= sclk;
    end
    // falls inside the current frame; select low empties it
    always_ff @(posedge clk) begin
        if (sys_rst || !sel) begin
            fall_cnt_reg <= 6'h00;
        end else if (sclk_reg && !sclk) begin
            fall_cnt_reg <= fall_cnt_reg + 6'h01;
        end
    end
    sel_frame_a:
        assert property ($fell(sel) |-> fall_cnt_reg == 6'h20)
        else $error("select dropped off a 32 clock frame");
    idle_clk_a:
        assert property (!sel |-> !sclk)
        else $error("serial clock moved outside a frame");
    clk_high_a:
        assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
        else $error("serial clock high phase not 8 cycles");
    sel_setup_a:
        assert property ($rose(sel) |-> !sclk[*2])
        else $error("serial clock rose with select");
    mosi_hold_a:
        assert property ($rose(sclk) |=> $stable(mosi))
        else $error("mosi moved after rising edge");
    miso_steady_a:
        assert property (sel && sclk && $past(sclk) |-> $stable(miso_o))
        else $error("miso moved while serial clock high");
    miso_drive_a:
        assert property (sel && fall_cnt_reg >= 6'h09 |-> !miso_oe_n)
        else $error("miso not driven in data phase");
    miso_release_a:
        assert property (!sel[*5] |-> miso_oe_n && !miso_i)
        else $error("miso not released with select low");
    cover property ($fell(sel) && fall_cnt_reg == 6'h20);
    cover property ($rose(sclk) && mosi && fall_cnt_reg == 6'h00);
    cover property (sel && !miso_oe_n && miso_o);
endmodule // sprap_link_asserts

// >>> tb/tb_top.sv
// serial register access port: host and device joined back to back
// assumes: design files and sprap_link_asserts compiled before this one
`timescale 1ns/100ps
`include "sprap_defs.svh"
module tb_top;
    logic clk;
    logic sys_rst;
    logic req_valid;
    logic req_ready;
    logic req_write;
    sprap_pkg::sprap_addr_t req_addr;
    sprap_pkg::sprap_data_t req_data;
    logic rsp_valid;
    sprap_pkg::sprap_data_t rsp_data;
    logic port_active;
    sprap_pkg::sprap_mode_t mode;
    logic [6:0] i2c_addr;
    logic write_pulse;
    sprap_pkg::sprap_addr_t write_addr;
    sprap_pkg::sprap_addr_t wp_addr;
    sprap_pkg::sprap_data_t got;
    int n_errors = 0;
    int checked = 0;
    int n_wp = 0;
    sprap_if link ();
    // a released miso falls to the board pull-down
    assign link.miso_i = link.miso_oe_n ? 1'b0 : link.miso_o;
    sprap_device sprap_device_i (.clk(clk), .sys_rst(sys_rst), .link(link),
        .hw_status(24'h000000), .hw_event(24'h000000), .hw_addr(6'h00),
        .port_active(port_active), .mode(mode), .i2c_slave_addr(i2c_addr),
        .write_pulse(write_pulse), .write_addr(write_addr));
    sprap_host sprap_host_i (.clk(clk), .sys_rst(sys_rst), .link(link),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_addr(req_addr), .req_data(req_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data));
    sprap_link_asserts sprap_link_asserts_i (.clk(clk), .sys_rst(sys_rst),
        .sel(link.sel), .sclk(link.sclk), .mosi(link.mosi),
        .miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n),
        .miso_i(link.miso_i));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (write_pulse === 1'b1) begin
            n_wp = n_wp + 1;
            wp_addr = write_addr;
        end
    end
    task automatic chk_word(input string what, input logic [23:0] exp,
            input logic [23:0] seen);
        checked = checked + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp,
            input logic seen);
        checked = checked + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %s expected %b seen %b", what, exp, seen);
        end
    endtask
    // one frame through the host, entered at a falling edge
    task automatic xfer(input logic wr, input sprap_pkg::sprap_addr_t a,
            input sprap_pkg::sprap_data_t d);
        int i;
        req_write = wr;
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        for (i = 0; i < 400 && req_ready !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        for (i = 0; i < 600 && rsp_valid !== 1'b1; i++) @(negedge clk);
        chk_bit("rsp_valid", 1'b1, rsp_valid);
        got = rsp_data;
    endtask
    // waits up to 16 cycles for a commit pulse; a write's pulse comes one clock before the host answer
    task automatic settle(input int w);
        int i;
        for (i = 0; i < 16 && n_wp == w; i++) @(negedge clk);
    endtask
    task automatic t_reset();
        chk_bit("port_active", 1'b1, port_active);
        chk_word("mode", {22'h000000, sprap_pkg::SPRAP_MODE_SPI},
            {22'h000000, mode});
        chk_word("slave addr", {17'h00000, `SPRAP_I2C_ADDR_HI, 1'b0},
            {17'h00000, i2c_addr});
        chk_bit("miso_oe_n", 1'b1, link.miso_oe_n);
        $display("test reset done");
    endtask
    task automatic t_write_read();
        sprap_pkg::sprap_addr_t ta [3] = '{6'h00, 6'h3F, 6'h15};
        sprap_pkg::sprap_data_t td [3] = '{24'hA55A3C, 24'hFFFFFF, 24'h800001};
        int k;
        int w;
        for (k = 0; k < 3; k++) begin
            w = n_wp;
            xfer(1'b1, ta[k], td[k]);
            chk_word("write echo", 24'h000000, got);
            settle(w);
            chk_bit("one commit", 1'b1, n_wp == w + 1);
            chk_word("commit addr", {18'h00000, ta[k]},
                {18'h00000, wp_addr});
        end
        w = n_wp;
        for (k = 0; k < 3; k++) begin
            xfer(1'b0, ta[k], 24'h000000);
            chk_word("read data", td[k], got);
        end
        settle(w);
        chk_bit("read commits none", 1'b1, n_wp == w);
        $display("test write read done");
    endtask
    task automatic t_overwrite();
        int w;
        xfer(1'b1, 6'h15, 24'h123456);
        chk_word("overwrite echo", 24'h800001, got);
        xfer(1'b1, 6'h3F, 24'h000000);
        chk_word("clear echo", 24'hFFFFFF, got);
        w = n_wp;
        xfer(1'b0, 6'h15, 24'hFFFFFF);
        chk_word("read with junk", 24'h123456, got);
        xfer(1'b0, 6'h15, 24'h000000);
        chk_word("read unchanged", 24'h123456, got);
        xfer(1'b0, 6'h3F, 24'h000000);
        chk_word("read cleared", 24'h000000, got);
        settle(w);
        chk_bit("reads commit none", 1'b1, n_wp == w);
        $display("test overwrite done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 6'h00;
        req_data = 24'h000000;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        t_reset();
        t_write_read();
        t_overwrite();
        end_of_test();
    end
    // about a dozen frames of some 530 cycles each
    initial begin
        repeat (20000) @(posedge clk);
        n_errors = n_errors + 1;
        end_of_test();
    end
endmodule // tb_top
